//--- design/i2c_ctrl_pkg.sv
// Constants, register map and state type of the two-wire bus controller.
// Assumes a 100 MHz system clock and a 100 kHz bus clock.
`default_nettype none

package i2c_ctrl_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CON  = 8'h00;
  localparam logic [7:0] ADDR_TXD  = 8'h04;
  localparam logic [7:0] ADDR_RXD  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int BIT_EN    = 15;
  localparam int BIT_SIDL  = 13;
  localparam int BIT_REL   = 12;
  localparam int BIT_IPMI  = 11;
  localparam int BIT_A10   = 10;
  localparam int BIT_SLW   = 9;
  localparam int BIT_SM    = 8;
  localparam int BIT_GC    = 7;
  localparam int BIT_STR   = 6;
  localparam int BIT_ACK_VALUE = 5;
  localparam int BIT_ACK_SEQUENCE_GO = 4;
  localparam int BIT_RECEIVE_GO  = 3;
  localparam int BIT_PEN   = 2;
  localparam int BIT_RESTART_GO  = 1;
  localparam int BIT_SEN   = 0;
  localparam logic [15:0] CON_RESET = 16'h1000;
  localparam logic [15:0] CON_WMASK = 16'hbfff;
  localparam logic [4:0]  GO_MASK   = 5'h1f;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int STAT_BUSY  = 0;
  localparam int STAT_NACK  = 1;
  localparam int STAT_RXV   = 2;
  localparam int STAT_RXF   = 3;
  localparam int STAT_TXB   = 4;
  localparam int STAT_PINS  = 5;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_PERIOD_NS = 10000;
  localparam int QUARTER_CYC   = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int STRAP_SYNC    = 2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RESTART, ST_STOP, ST_TX, ST_RX, ST_ACK
  } eng_state_t;

endpackage

`default_nettype wire

//--- design/i2c_ctrl.sv
// Two-wire bus master controller with APB register access.
// Assumes external pull-ups on all bus pins; the bench resolves the wires.
// Functional notes
// R1: Bus pins fixed, not remappable.
// R2: Config bit 0 routes to alternate pins.
// R3: Master opens with a Start condition.
// R4: Send address and bytes, check acknowledge.
// R5: Repeated Start, then read address, acknowledged.
// R6: Receive enable clocks in slave bytes.
// R7: Drive ACK or NACK after each byte.
// R8: Master ends with a Stop condition.
// R9: Enable bit hands pins to serial port.
// R10: Stop-in-idle halts module in Idle.
// R11: Release bit clear holds clock low.
// R12: Release writable per stretch mode, hardware clears.
// R13: Command bits self-clear when action completes.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none

module i2c_ctrl #(
  parameter int QUARTER = i2c_ctrl_pkg::QUARTER_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_mode,
  input  wire logic        slave_tx_begin,
  input  wire logic        alt_pin_select_cfg,
  output logic             pins_serial,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        alt_clock_pin_i,
  output logic             alt_clock_pin_o,
  output logic             alt_clock_pin_oe,
  input  wire logic        alt_data_pin_i,
  output logic             alt_data_pin_o,
  output logic             alt_data_pin_oe
);

  localparam logic [15:0] QM1 = 16'(QUARTER - 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] last_phase(input i2c_ctrl_pkg::eng_state_t s);
    case (s)
      i2c_ctrl_pkg::ST_START: last_phase = 2'd2;
      i2c_ctrl_pkg::ST_STOP:  last_phase = 2'd2;
      default:                last_phase = 2'd3;
    endcase
  endfunction

  function automatic logic [3:0] last_bit(input i2c_ctrl_pkg::eng_state_t s);
    case (s)
      i2c_ctrl_pkg::ST_TX: last_bit = 4'd8;
      i2c_ctrl_pkg::ST_RX: last_bit = 4'd7;
      default:             last_bit = 4'd0;
    endcase
  endfunction

  i2c_ctrl_pkg::eng_state_t state_r;
  logic [15:0] con_r, con_nxt;
  logic [15:0] qcnt_r;
  logic [1:0]  phase_r;
  logic [3:0]  bitn_r;
  logic [7:0]  shift_r, txd_r;
  logic        tx_req_r, nack_r;
  logic        scl_drv_r, sda_drv_r, scl_nxt, sda_nxt;
  logic        scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  logic [1:0]  strap_r;
  logic [1:0]  strap_cnt_r;
  logic        alt_sel_r;
  logic [7:0]  buf_mem [0:1];
  logic        buf_wp_r, buf_rp_r;
  logic [1:0]  buf_cnt_r;

  // ****************************************
  // APB slave
  // ****************************************
  logic en, halt, wr, rd_setup, mapped, busy_st, wait_scl, tick, op_done;
  logic buf_in_ready, buf_out_valid, buf_pop, push;

  assign en       = con_r[i2c_ctrl_pkg::BIT_EN];
  assign halt     = con_r[i2c_ctrl_pkg::BIT_SIDL] & idle_mode; // [R10]
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr == i2c_ctrl_pkg::ADDR_CON) ||
                    (paddr == i2c_ctrl_pkg::ADDR_TXD) ||
                    (paddr == i2c_ctrl_pkg::ADDR_RXD) ||
                    (paddr == i2c_ctrl_pkg::ADDR_STAT);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign buf_pop  = psel & penable & ~pwrite &
                    (paddr == i2c_ctrl_pkg::ADDR_RXD) & buf_out_valid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        i2c_ctrl_pkg::ADDR_CON:  prdata <= {16'h0000, con_r};
        i2c_ctrl_pkg::ADDR_TXD:  prdata <= {24'h000000, txd_r};
        i2c_ctrl_pkg::ADDR_RXD:  prdata <= {24'h000000,
                                            buf_mem[buf_rp_r]};
        i2c_ctrl_pkg::ADDR_STAT: begin
          prdata <= 32'h0000_0000;
          prdata[i2c_ctrl_pkg::STAT_BUSY] <= busy_st;
          prdata[i2c_ctrl_pkg::STAT_NACK] <= nack_r;
          prdata[i2c_ctrl_pkg::STAT_RXV]  <= buf_out_valid;
          prdata[i2c_ctrl_pkg::STAT_RXF]  <= ~buf_in_ready;
          prdata[i2c_ctrl_pkg::STAT_TXB]  <= tx_req_r |
                                (state_r == i2c_ctrl_pkg::ST_TX);
          prdata[i2c_ctrl_pkg::STAT_PINS] <= en;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_comb begin
    con_nxt = con_r;
    if (op_done) begin
      case (state_r) // [R13]
        i2c_ctrl_pkg::ST_START:   con_nxt[i2c_ctrl_pkg::BIT_SEN]   = 1'b0;
        i2c_ctrl_pkg::ST_RESTART: con_nxt[i2c_ctrl_pkg::BIT_RESTART_GO]  = 1'b0;
        i2c_ctrl_pkg::ST_STOP:    con_nxt[i2c_ctrl_pkg::BIT_PEN]   = 1'b0;
        i2c_ctrl_pkg::ST_RX:      con_nxt[i2c_ctrl_pkg::BIT_RECEIVE_GO]  = 1'b0;
        i2c_ctrl_pkg::ST_ACK:     con_nxt[i2c_ctrl_pkg::BIT_ACK_SEQUENCE_GO] = 1'b0;
        default: ;
      endcase
    end
    if (!en) begin
      con_nxt[4:0] = ~i2c_ctrl_pkg::GO_MASK & con_nxt[4:0];
    end
    if (slave_tx_begin) begin
      con_nxt[i2c_ctrl_pkg::BIT_REL] = 1'b0; // [R12]
    end
    if (wr && paddr == i2c_ctrl_pkg::ADDR_CON) begin
      con_nxt = {con_nxt[15:13] & 3'b010, con_nxt[12], 12'h000} |
                (pwdata[15:0] & i2c_ctrl_pkg::CON_WMASK &
                 ~(16'h1 << i2c_ctrl_pkg::BIT_REL));
      // Without stretching only a 1 may be written to release
      if (con_r[i2c_ctrl_pkg::BIT_STR] ||
          pwdata[i2c_ctrl_pkg::BIT_REL]) begin
        con_nxt[i2c_ctrl_pkg::BIT_REL] = pwdata[i2c_ctrl_pkg::BIT_REL];
      end // [R12]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      con_r <= i2c_ctrl_pkg::CON_RESET;
    end else begin
      con_r <= con_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txd_r    <= 8'h00;
      tx_req_r <= 1'b0;
    end else begin
      if (state_r == i2c_ctrl_pkg::ST_IDLE && tx_req_r && en && !halt &&
          con_r[4:0] == 5'h00) begin
        tx_req_r <= 1'b0;
      end else if (!en) begin
        tx_req_r <= 1'b0;
      end
      if (wr && paddr == i2c_ctrl_pkg::ADDR_TXD && !tx_req_r &&
          state_r != i2c_ctrl_pkg::ST_TX) begin
        txd_r    <= pwdata[7:0];
        tx_req_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Pin routing and input synchronisers
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_r     <= 2'b11;
      strap_cnt_r <= 2'd0;
      alt_sel_r   <= 1'b1;
    end else begin
      strap_r <= {strap_r[0], alt_pin_select_cfg};
      if (strap_cnt_r != 2'(i2c_ctrl_pkg::STRAP_SYNC + 1)) begin
        strap_cnt_r <= strap_cnt_r + 2'd1;
        alt_sel_r   <= strap_r[1]; // [R2]
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= alt_sel_r ? scl_i : alt_clock_pin_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= alt_sel_r ? sda_i : alt_data_pin_i;
      sda_s_r <= sda_m_r;
    end
  end

  logic scl_low, sda_low;
  // Slave clock stretch holds the clock low while release is clear
  assign scl_low = en & (scl_drv_r | ~con_r[i2c_ctrl_pkg::BIT_REL]); // [R11]
  assign sda_low = en & sda_drv_r;
  // Fixed pin pairs; only the config bit can move them [R1]
  assign scl_oe           = scl_low & alt_sel_r; // [R9]
  assign sda_oe           = sda_low & alt_sel_r;
  assign alt_clock_pin_oe = scl_low & ~alt_sel_r; // [R2]
  assign alt_data_pin_oe  = sda_low & ~alt_sel_r;
  assign scl_o            = 1'b0;
  assign sda_o            = 1'b0;
  assign alt_clock_pin_o  = 1'b0;
  assign alt_data_pin_o   = 1'b0;
  assign pins_serial      = en; // [R9]

  // ****************************************
  // Two-entry receive buffer
  // ****************************************
  assign buf_in_ready  = (buf_cnt_r != 2'd2);
  assign buf_out_valid = (buf_cnt_r != 2'd0);
  assign push = op_done & (state_r == i2c_ctrl_pkg::ST_RX);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_wp_r   <= 1'b0;
      buf_rp_r   <= 1'b0;
      buf_cnt_r  <= 2'd0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else begin
      if (push) begin
        buf_mem[buf_wp_r] <= shift_r;
        buf_wp_r          <= ~buf_wp_r;
      end
      if (buf_pop) begin
        buf_rp_r <= ~buf_rp_r;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, buf_pop};
    end
  end

  // ****************************************
  // Bus engine
  // ****************************************
  assign busy_st  = (state_r != i2c_ctrl_pkg::ST_IDLE);
  assign wait_scl = ~scl_drv_r & ~scl_s_r;
  assign tick     = busy_st & ~halt & ~wait_scl & (qcnt_r == QM1);
  assign op_done  = tick & (phase_r == last_phase(state_r)) &
                    (bitn_r == last_bit(state_r));

  always_comb begin
    scl_nxt = 1'b0;
    sda_nxt = 1'b0;
    case (state_r)
      i2c_ctrl_pkg::ST_START: begin // [R3]
        scl_nxt = (phase_r == 2'd2);
        sda_nxt = (phase_r != 2'd0);
      end
      i2c_ctrl_pkg::ST_RESTART: begin // [R5]
        scl_nxt = (phase_r == 2'd0) || (phase_r == 2'd3);
        sda_nxt = (phase_r >= 2'd2);
      end
      i2c_ctrl_pkg::ST_STOP: begin // [R8]
        scl_nxt = (phase_r == 2'd0);
        sda_nxt = (phase_r != 2'd2);
      end
      i2c_ctrl_pkg::ST_TX: begin // [R4]
        scl_nxt = (phase_r == 2'd0) || (phase_r == 2'd3);
        sda_nxt = (bitn_r != 4'd8) && !shift_r[7];
      end
      i2c_ctrl_pkg::ST_RX: begin // [R6]
        scl_nxt = (phase_r == 2'd0) || (phase_r == 2'd3);
        sda_nxt = 1'b0;
      end
      i2c_ctrl_pkg::ST_ACK: begin // [R7]
        scl_nxt = (phase_r == 2'd0) || (phase_r == 2'd3);
        sda_nxt = ~con_r[i2c_ctrl_pkg::BIT_ACK_VALUE];
      end
      default: begin
        scl_nxt = scl_drv_r;
        sda_nxt = sda_drv_r;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end else if (!en) begin
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end else begin
      scl_drv_r <= scl_nxt;
      sda_drv_r <= sda_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      qcnt_r <= 16'h0000;
    end else if (!busy_st || tick) begin
      qcnt_r <= 16'h0000;
    end else if (!halt && !wait_scl) begin
      qcnt_r <= qcnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= i2c_ctrl_pkg::ST_IDLE;
      phase_r <= 2'd0;
      bitn_r  <= 4'd0;
      shift_r <= 8'h00;
      nack_r  <= 1'b0;
    end else if (!en) begin
      state_r <= i2c_ctrl_pkg::ST_IDLE;
      phase_r <= 2'd0;
      bitn_r  <= 4'd0;
    end else if (!busy_st) begin
      phase_r <= 2'd0;
      bitn_r  <= 4'd0;
      if (!halt) begin
        if (con_r[i2c_ctrl_pkg::BIT_SEN]) begin
          state_r <= i2c_ctrl_pkg::ST_START;
        end else if (con_r[i2c_ctrl_pkg::BIT_RESTART_GO]) begin
          state_r <= i2c_ctrl_pkg::ST_RESTART;
        end else if (con_r[i2c_ctrl_pkg::BIT_PEN]) begin
          state_r <= i2c_ctrl_pkg::ST_STOP;
        end else if (con_r[i2c_ctrl_pkg::BIT_RECEIVE_GO]) begin
          if (buf_in_ready) begin // [R6]
            state_r <= i2c_ctrl_pkg::ST_RX;
          end
        end else if (con_r[i2c_ctrl_pkg::BIT_ACK_SEQUENCE_GO]) begin
          state_r <= i2c_ctrl_pkg::ST_ACK;
        end else if (tx_req_r) begin
          state_r <= i2c_ctrl_pkg::ST_TX;
          shift_r <= txd_r;
        end
      end
    end else if (tick) begin
      if (phase_r == 2'd2 && state_r == i2c_ctrl_pkg::ST_RX) begin
        shift_r <= {shift_r[6:0], sda_s_r};
      end
      if (phase_r == 2'd2 && state_r == i2c_ctrl_pkg::ST_TX &&
          bitn_r == 4'd8) begin
        nack_r <= sda_s_r; // [R4]
      end
      if (phase_r == 2'd3 && state_r == i2c_ctrl_pkg::ST_TX) begin
        shift_r <= {shift_r[6:0], 1'b0};
      end
      if (op_done) begin
        state_r <= i2c_ctrl_pkg::ST_IDLE;
        phase_r <= 2'd0;
      end else if (phase_r == last_phase(state_r)) begin
        phase_r <= 2'd0;
        bitn_r  <= bitn_r + 4'd1;
      end else begin
        phase_r <= phase_r + 2'd1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_stop_last;
    state_r == i2c_ctrl_pkg::ST_STOP && op_done;
  endsequence

  property p_start_order;
    @(posedge clk) disable iff (!nrst)
      (state_r == i2c_ctrl_pkg::ST_START && phase_r == 2'd2 && en)
      |=> (scl_drv_r && sda_drv_r);
  endproperty
  a_start_order: assert property (p_start_order) // [R3]
    else $error("start did not pull both lines low");

  property p_stop_release;
    @(posedge clk) disable iff (!nrst)
      s_stop_last |=> (!sda_drv_r && !scl_drv_r &&
                       !con_r[i2c_ctrl_pkg::BIT_PEN]);
  endproperty
  a_stop_release: assert property (p_stop_release) // [R8]
    else $error("stop did not release bus or clear its bit");

  property p_disable_pins;
    @(posedge clk) disable iff (!nrst)
      !en |-> (!scl_oe && !sda_oe && !alt_clock_pin_oe &&
               !alt_data_pin_oe && !pins_serial);
  endproperty
  a_disable_pins: assert property (p_disable_pins) // [R9]
    else $error("pins driven while module disabled");

  property p_stretch_hold;
    @(posedge clk) disable iff (!nrst)
      (en && !con_r[i2c_ctrl_pkg::BIT_REL]) |-> (scl_oe || alt_clock_pin_oe);
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) // [R11]
    else $error("clock not held low with release clear");

  property p_rel_no_zero;
    @(posedge clk) disable iff (!nrst)
      (wr && paddr == i2c_ctrl_pkg::ADDR_CON && !pwdata[i2c_ctrl_pkg::BIT_REL]
       && !con_r[i2c_ctrl_pkg::BIT_STR] && con_r[i2c_ctrl_pkg::BIT_REL]
       && !slave_tx_begin) |=> con_r[i2c_ctrl_pkg::BIT_REL];
  endproperty
  a_rel_no_zero: assert property (p_rel_no_zero) // [R12]
    else $error("release cleared by software without stretching");

  property p_rel_hw_clear;
    @(posedge clk) disable iff (!nrst)
      (slave_tx_begin && !(wr && paddr == i2c_ctrl_pkg::ADDR_CON))
      |=> !con_r[i2c_ctrl_pkg::BIT_REL];
  endproperty
  a_rel_hw_clear: assert property (p_rel_hw_clear) // [R12]
    else $error("release not cleared at slave transmit");

  property p_ack_value;
    @(posedge clk) disable iff (!nrst)
      (state_r == i2c_ctrl_pkg::ST_ACK && phase_r == 2'd2 &&
       $stable(con_r[i2c_ctrl_pkg::BIT_ACK_VALUE]))
      |-> (sda_drv_r == !con_r[i2c_ctrl_pkg::BIT_ACK_VALUE]);
  endproperty
  a_ack_value: assert property (p_ack_value) // [R7]
    else $error("acknowledge level differs from chosen value");

  property p_tx_ack_release;
    @(posedge clk) disable iff (!nrst)
      (state_r == i2c_ctrl_pkg::ST_TX && bitn_r == 4'd8 && phase_r == 2'd2)
      |-> !sda_drv_r;
  endproperty
  a_tx_ack_release: assert property (p_tx_ack_release) // [R4]
    else $error("data line not released for slave acknowledge");

  property p_idle_halt;
    @(posedge clk) disable iff (!nrst)
      (halt && busy_st && en) |=> ($stable(qcnt_r) || qcnt_r == 16'h0000);
  endproperty
  a_idle_halt: assert property (p_idle_halt) // [R10]
    else $error("bit timer advanced while halted in idle");

  property p_rx_push;
    @(posedge clk) disable iff (!nrst)
      (push && !buf_pop) |=> (buf_cnt_r == $past(buf_cnt_r) + 2'd1 &&
                              !con_r[i2c_ctrl_pkg::BIT_RECEIVE_GO]);
  endproperty
  a_rx_push: assert property (p_rx_push) // [R13]
    else $error("received byte not buffered or go bit left set");

  property p_alt_route;
    @(posedge clk) disable iff (!nrst)
      (!alt_sel_r && en && scl_drv_r) |-> (alt_clock_pin_oe && !scl_oe);
  endproperty
  a_alt_route: assert property (p_alt_route) // [R2]
    else $error("clock not routed to alternate pin");

endmodule

`default_nettype wire

//--- tb/i2c_slave_model.sv
// Behavioural target device on the two-wire bus.
// Assumes resolved clock and data lines with pull-ups.
`default_nettype none

module i2c_slave_model #(
  parameter logic [6:0] ADDR  = 7'h50,
  parameter logic [7:0] FIRST = 8'ha5
) (
  input  wire logic       clk,
  input  wire logic       scl,
  input  wire logic       sda,
  output var  logic       sda_oe,
  output var  logic [7:0] got
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic       act = 1'b0;
  logic       first;
  logic       rd;
  logic [3:0] n;
  logic [7:0] sh;
  logic [7:0] txd = FIRST;
  wire        hit = (sh[7:1] == ADDR);

  initial sda_oe = 1'b0;

  // ****************************************
  // Framing, shifting and acknowledge
  // ****************************************
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      act <= 1'b1;
      first <= 1'b1;
      n <= 4'h0;
      rd <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      act <= 1'b0;
      sda_oe <= 1'b0;
    end else if (act && scl && !scl_q) begin
      if (n < 4'h8) begin
        sh <= {sh[6:0], sda};
        n <= n + 4'h1;
      end else begin
        n <= 4'h0;
        first <= 1'b0;
        if (!first && !rd) got <= sh;
        if (rd && !first) txd <= txd + 8'h01;
        if (rd && !first && sda) act <= 1'b0; // Quiet after NACK
        if (first && !hit) act <= 1'b0;
      end
    end else if (act && !scl && scl_q) begin
      if (n == 4'h8) begin
        if (first) rd <= sh[0];
        sda_oe <= first ? hit : !rd;
      end else begin
        sda_oe <= rd && !first && !txd[3'd7 - n[2:0]];
      end
    end
  end
endmodule

`default_nettype wire

//--- tb/test_i2c_master_slave_control.sv
// Self-checking bench for the two-wire bus controller.
// Assumes pulled-up bus pins and a target model on the primary pins.
`default_nettype none

module test_i2c_master_slave_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        idle_mode = 1'b0;
  logic        slave_tx_begin = 1'b0;
  logic        strap = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, pins_serial, scl_oe, sda_oe, s_oe;
  logic        acl_oe, ada_oe, last_bit;
  logic        scl_q = 1'b1;
  logic        sda_q = 1'b1;
  logic [7:0]  got;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n_start = 0;
  int          n_stop = 0;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | s_oe);
  wire         acl = ~acl_oe;
  wire         ada = ~ada_oe;

  i2c_ctrl #(.QUARTER(4)) dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .slave_tx_begin(slave_tx_begin),
    .alt_pin_select_cfg(strap), .pins_serial(pins_serial),
    .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .alt_clock_pin_i(acl), .alt_clock_pin_o(), .alt_clock_pin_oe(acl_oe),
    .alt_data_pin_i(ada), .alt_data_pin_o(), .alt_data_pin_oe(ada_oe));

  i2c_slave_model #(.ADDR(7'h50), .FIRST(8'ha5)) target (.clk(clk),
    .scl(scl), .sda(sda), .sda_oe(s_oe), .got(got));

  // ****************************************
  // Clock, wire watch and timeout
  // ****************************************
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) n_start <= n_start + 1;
    if (scl && scl_q && !sda_q && sda) n_stop <= n_stop + 1;
    if (scl && !scl_q) last_bit <= sda;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] m, e);
    logic [31:0] q;
    logic        er;
    apb(1'b0, a, 32'h0, q, er);
    chk(nm, e, q & m);
  endtask

  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] q;
    logic        e;
    repeat (3000) begin
      apb(1'b0, a, 32'h0, q, e);
      if (q[b] === 1'b0) return;
    end
    chk("go bit", 32'h0, 32'h1);
  endtask

  task automatic cmd(input logic [31:0] d, input int b);
    wr(i2c_ctrl_pkg::ADDR_CON, d);
    poll(i2c_ctrl_pkg::ADDR_CON, b);
  endtask

  task automatic tx(input logic [7:0] d, input logic nack);
    wr(i2c_ctrl_pkg::ADDR_TXD, {24'h0, d});
    poll(i2c_ctrl_pkg::ADDR_STAT, i2c_ctrl_pkg::STAT_TXB);
    rd("nack", i2c_ctrl_pkg::ADDR_STAT, 32'h2, {30'h0, nack, 1'b0});
  endtask

  task automatic do_reset(input logic s);
    nrst <= 1'b0;
    strap <= s;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd("con reset", i2c_ctrl_pkg::ADDR_CON, 32'hffff, 32'h1000);
    wr(i2c_ctrl_pkg::ADDR_CON, 32'h0000);
    rd("rel", i2c_ctrl_pkg::ADDR_CON, 32'hffff, 32'h1000);
    wr(i2c_ctrl_pkg::ADDR_CON, 32'h0040);
    rd("rel", i2c_ctrl_pkg::ADDR_CON, 32'hffff, 32'h1040);
    wr(i2c_ctrl_pkg::ADDR_CON, 32'h0040);
    rd("rel", i2c_ctrl_pkg::ADDR_CON, 32'hffff, 32'h0040);
    wr(i2c_ctrl_pkg::ADDR_CON, 32'h9040);
    slave_tx_begin <= 1'b1;
    @(posedge clk);
    slave_tx_begin <= 1'b0;
    rd("rel", i2c_ctrl_pkg::ADDR_CON, 32'hffff, 32'h8040);
    chk("stretch", 32'h1, {31'h0, scl_oe});
    wr(i2c_ctrl_pkg::ADDR_CON, 32'h1000);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask

  task automatic t_transfer();
    wr(i2c_ctrl_pkg::ADDR_CON, 32'hb001);
    @(posedge clk);
    idle_mode <= 1'b1;
    repeat (40) @(posedge clk);
    rd("halted", i2c_ctrl_pkg::ADDR_CON, 32'h1, 32'h1);
    chk("pins", 32'h1, {31'h0, pins_serial});
    idle_mode <= 1'b0;
    poll(i2c_ctrl_pkg::ADDR_CON, i2c_ctrl_pkg::BIT_SEN);
    chk("start", 32'h1, n_start);
    tx(8'ha0, 1'b0);
    tx(8'h3c, 1'b0);
    chk("target byte", 32'h3c, {24'h0, got});
    cmd(32'h9002, i2c_ctrl_pkg::BIT_RESTART_GO);
    chk("restart", 32'h2, n_start);
    tx(8'ha1, 1'b0);
    repeat (2) begin
      cmd(32'h9008, i2c_ctrl_pkg::BIT_RECEIVE_GO);
      cmd(32'h9010, i2c_ctrl_pkg::BIT_ACK_SEQUENCE_GO);
      chk("ack level", 32'h0, {31'h0, last_bit});
    end
    rd("full", i2c_ctrl_pkg::ADDR_STAT, 32'hc, 32'hc);
    wr(i2c_ctrl_pkg::ADDR_CON, 32'h9008);
    repeat (40) @(posedge clk);
    rd("rx refused", i2c_ctrl_pkg::ADDR_CON, 32'h8, 32'h8);
    rd("rx data", i2c_ctrl_pkg::ADDR_RXD, 32'hff, 32'ha5);
    poll(i2c_ctrl_pkg::ADDR_CON, i2c_ctrl_pkg::BIT_RECEIVE_GO);
    cmd(32'h9030, i2c_ctrl_pkg::BIT_ACK_SEQUENCE_GO);
    chk("nack level", 32'h1, {31'h0, last_bit});
    cmd(32'h9004, i2c_ctrl_pkg::BIT_PEN);
    chk("stop", 32'h1, n_stop);
    rd("rx data", i2c_ctrl_pkg::ADDR_RXD, 32'hff, 32'ha6);
    rd("rx data", i2c_ctrl_pkg::ADDR_RXD, 32'hff, 32'ha7);
    rd("empty", i2c_ctrl_pkg::ADDR_STAT, 32'h4, 32'h0);
  endtask

  task automatic t_nack();
    cmd(32'h9001, i2c_ctrl_pkg::BIT_SEN);
    tx(8'h22, 1'b1);
    cmd(32'h9004, i2c_ctrl_pkg::BIT_PEN);
  endtask

  task automatic t_disable();
    wr(i2c_ctrl_pkg::ADDR_CON, 32'h1000);
    @(posedge clk);
    chk("pins", 32'h0, {29'h0, pins_serial, scl_oe, sda_oe});
  endtask

  task automatic t_alt_pins();
    do_reset(1'b0);
    cmd(32'h9001, i2c_ctrl_pkg::BIT_SEN);
    chk("alt oe", 32'hc, {28'h0, ada_oe, acl_oe, sda_oe, scl_oe});
  endtask

  task automatic complete_run();
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    do_reset(1'b1);
    t_regs();
    t_transfer();
    t_nack();
    t_disable();
    t_alt_pins();
    complete_run();
  end
endmodule

`default_nettype wire
